/* src/doc_osc_ctrl.sv */
// Function
// - Fast oscillator frequency select: 0 2 MHz, 1 1 MHz, 2 500 kHz.
// - Fast oscillator runs while its enable is 1, stops at 0.
// - Fast oscillator stops in sleep regardless of enable.
// - Reset sets fast enable 1; fast oscillator is system clock.
// - Fast clock withheld until its stabilization wait elapses.
// - Fast wait select: 3 8, 2 16, 1 32, 0 64 cycles.
// - Core starts after fast start plus 64 fast cycles.
// - Outside sleep slow oscillator follows its enable only.
// - In sleep slow oscillator runs only with enable and calendar run.
// - Reset clears slow enable and calendar run; slow oscillator halted.
// - Slow wait select: 0 16384, 2 4096 cycles; others reserved.
// - Selected clock reaches system by start time plus wait.
// - Calendar start resets slow divider chain and 256 Hz tap.
// - Clock output pins are general I/O until function selected.
// - Sleep cancel forces fast enable and fast system clock.
// - Disabling the selected source oscillator is ignored.
`timescale 1ns/1ps
`default_nettype none
`include "doc_defines.svh"
module doc_osc_ctrl #(
    parameter int SLOW_WAIT_LONG = `DOC_SLOW_WAIT_LONG,
    parameter int SLOW_WAIT_SHORT = `DOC_SLOW_WAIT_SHORT
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic sleep,
    input wire logic sleep_cancel,
    input wire logic crystal_in_pin,
    output logic crystal_out_pin,
    input wire logic gpio_a,
    input wire logic gpio_b,
    output logic clock_out_a,
    output logic clock_out_b,
    output logic [1:0] sysclk_source_sel,
    output logic sysclk_tick,
    output logic core_run,
    output logic fast_osc_run,
    output logic slow_osc_run,
    output logic fast_clk_valid,
    output logic slow_clk_valid,
    output logic tap_256hz,
    output logic slow_div_reset
);
    localparam doc_pkg::doc_main_st_t MAIN_RST = '{
        src: `DOC_SRC_FAST, fsel: `DOC_FSEL_RST, fen: `DOC_FEN_RST,
        sen: `DOC_SEN_RST, fwt: `DOC_FWT_RST, swt: `DOC_SWT_RST,
        cal: `DOC_CAL_RST, fast_run: `DOC_FEN_RST, default: '0};

    if (SLOW_WAIT_LONG < 1 || SLOW_WAIT_LONG > 65535 || SLOW_WAIT_SHORT < 1 || SLOW_WAIT_SHORT > 65535)
    begin : g_check
        $error("slow wait counts must lie in 1 to 65535");
    end

    doc_pkg::doc_main_st_t s;
    doc_pkg::doc_main_st_t next_s;
    logic fast_tick;
    logic fast_valid;
    logic slow_valid;

    function automatic logic [15:0] slow_wait(input logic [1:0] sel);
        if (sel == 2'h2)
            slow_wait = 16'(SLOW_WAIT_SHORT);
        else
            slow_wait = 16'(SLOW_WAIT_LONG);
    endfunction

    doc_fast_osc u_fast_osc (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .run(s.fast_run),
        .freq_sel(s.fsel),
        .tick(fast_tick)
    );

    doc_osc_wait u_fast_wait (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .run(s.fast_run),
        .tick(fast_tick),
        .limit(doc_pkg::fast_wait(s.fwt)),
        .valid(fast_valid)
    );

    doc_osc_wait u_slow_wait (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .run(s.slow_run),
        .tick(s.slow_tick),
        .limit(slow_wait(s.swt)),
        .valid(slow_valid)
    );

    always_comb
    begin
        next_s = s;
        next_s.div_rst = 1'b0;
        next_s.tap = 1'b0;
        next_s.rdata = 16'h0000;
        // Register writes
        if (reg_wr)
        begin
            unique case (reg_addr)
                `DOC_ADDR_SRC:
                begin
                    next_s.fsel = reg_wdata[`DOC_FSEL_LSB +: 2];
                    if (reg_wdata[`DOC_SRC_LSB +: 2] == `DOC_SRC_FAST && s.fen)
                        next_s.src = `DOC_SRC_FAST;
                    else if (reg_wdata[`DOC_SRC_LSB +: 2] == `DOC_SRC_SLOW && s.sen)
                        next_s.src = `DOC_SRC_SLOW;
                end
                `DOC_ADDR_CTL:
                begin
                    next_s.fen = reg_wdata[`DOC_FEN_BIT] | (s.src == `DOC_SRC_FAST);
                    next_s.sen = reg_wdata[`DOC_SEN_BIT] | (s.src == `DOC_SRC_SLOW);
                end
                `DOC_ADDR_WAIT:
                begin
                    next_s.fwt = reg_wdata[`DOC_FWT_LSB +: 2];
                    next_s.swt = reg_wdata[`DOC_SWT_LSB +: 2];
                end
                `DOC_ADDR_CAL:
                begin
                    next_s.cal = reg_wdata[`DOC_CAL_BIT];
                    next_s.div_rst = reg_wdata[`DOC_CAL_BIT] & ~s.cal;
                end
                `DOC_ADDR_PORT:
                begin
                    next_s.port_a = reg_wdata[`DOC_PORTA_BIT];
                    next_s.port_b = reg_wdata[`DOC_PORTB_BIT];
                end
                default:
                begin
                end
            endcase
        end
        // Wake-up overrides any write to fast enable and source select
        if (sleep_cancel)
        begin
            next_s.fen = 1'b1;
            next_s.src = `DOC_SRC_FAST;
        end
        // Register reads, data in the following cycle
        if (reg_rd)
        begin
            unique case (reg_addr)
                `DOC_ADDR_SRC:
                begin
                    next_s.rdata[`DOC_SRC_LSB +: 2] = s.src;
                    next_s.rdata[`DOC_FSEL_LSB +: 2] = s.fsel;
                end
                `DOC_ADDR_CTL:
                begin
                    next_s.rdata[`DOC_FEN_BIT] = s.fen;
                    next_s.rdata[`DOC_SEN_BIT] = s.sen;
                end
                `DOC_ADDR_WAIT:
                begin
                    next_s.rdata[`DOC_FWT_LSB +: 2] = s.fwt;
                    next_s.rdata[`DOC_SWT_LSB +: 2] = s.swt;
                end
                `DOC_ADDR_CAL:
                begin
                    next_s.rdata[`DOC_CAL_BIT] = s.cal;
                    next_s.rdata[`DOC_FVAL_BIT] = fast_valid;
                    next_s.rdata[`DOC_SVAL_BIT] = slow_valid;
                    next_s.rdata[`DOC_FRUN_BIT] = s.fast_run;
                    next_s.rdata[`DOC_SRUN_BIT] = s.slow_run;
                end
                `DOC_ADDR_PORT:
                begin
                    next_s.rdata[`DOC_PORTA_BIT] = s.port_a;
                    next_s.rdata[`DOC_PORTB_BIT] = s.port_b;
                end
                default:
                begin
                end
            endcase
        end
        // Oscillator on/off
        next_s.fast_run = s.fen & ~sleep;
        next_s.slow_run = s.sen & (~sleep | s.cal);
        // Crystal input synchroniser and edge
        next_s.xsync = {s.xsync[1:0], crystal_in_pin};
        next_s.slow_tick = s.slow_run & s.xsync[1] & ~s.xsync[2];
        next_s.xout = s.slow_run & ~s.xsync[2];
        // Slow divider chain and 256 Hz tap
        if (s.div_rst)
        begin
            next_s.tap_cnt = 7'h00;
        end
        else if (s.slow_tick)
        begin
            next_s.tap_cnt = s.tap_cnt + 7'h01;
            next_s.tap = (s.tap_cnt == `DOC_TAP_DIV);
        end
        // System clock enable, gated by the wait
        if (s.src == `DOC_SRC_SLOW)
            next_s.sys_tick = s.slow_tick & slow_valid;
        else
            next_s.sys_tick = fast_tick & fast_valid;
        next_s.core_run = s.core_run | fast_valid;
        // Divided clock onto function-selected pins
        if (fast_tick & fast_valid)
            next_s.fdiv = ~s.fdiv;
        next_s.out_a = s.port_a ? s.fdiv : gpio_a;
        next_s.out_b = s.port_b ? s.fdiv : gpio_b;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            s <= MAIN_RST;
        else
            s <= next_s;
    end

    assign reg_rdata = s.rdata;
    assign crystal_out_pin = s.xout;
    assign clock_out_a = s.out_a;
    assign clock_out_b = s.out_b;
    assign sysclk_source_sel = s.src;
    assign sysclk_tick = s.sys_tick;
    assign core_run = s.core_run;
    assign fast_osc_run = s.fast_run;
    assign slow_osc_run = s.slow_run;
    assign fast_clk_valid = fast_valid;
    assign slow_clk_valid = slow_valid;
    assign tap_256hz = s.tap;
    assign slow_div_reset = s.div_rst;

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    a_fast_en_run: assert property (!sleep && s.fen |=> fast_osc_run)
        else $error("fast oscillator not running while enabled");
    a_sleep_fast_off: assert property (sleep |=> !fast_osc_run)
        else $error("fast oscillator running in sleep");
    a_slow_sleep_gate: assert property (sleep && !(s.sen && s.cal) |=> !slow_osc_run)
        else $error("slow oscillator running in sleep without calendar");
    a_reset_defaults: assert property ($past(sys_rst) |-> s.fen && !s.sen && !s.cal
        && s.src == 2'h0 && s.fwt == 2'h0 && s.swt == 2'h0)
        else $error("wrong reset defaults");
    a_cancel_force: assert property (sleep_cancel |=> s.fen && sysclk_source_sel == 2'h0)
        else $error("sleep cancel did not force fast clock");
    a_sel_protect: assert property (reg_wr && reg_addr == 5'h04 && !reg_wdata[0]
        && s.src == 2'h0 |=> s.fen)
        else $error("selected fast oscillator was disabled");
    a_clk_withheld: assert property (s.src == 2'h0 && !fast_clk_valid |=> !sysclk_tick)
        else $error("fast clock passed before wait end");
    a_core_hold: assert property (!fast_clk_valid && !core_run |=> !core_run)
        else $error("core started before fast wait");
    a_cal_div_reset: assert property (reg_wr && reg_addr == 5'h0C && reg_wdata[0] && !s.cal
        |=> slow_div_reset ##1 s.tap_cnt == 7'h00 && !slow_div_reset)
        else $error("calendar start did not reset divider");
    a_wait_stop_clear: assert property (!fast_osc_run |=> !fast_clk_valid)
        else $error("fast valid held after stop");
    a_gpio_default: assert property (!s.port_a |=> clock_out_a == $past(gpio_a))
        else $error("pin not general I/O by default");
    a_fast_wait_min: assert property ($rose(fast_osc_run) |-> !fast_clk_valid [*8])
        else $error("fast wait shorter than eight ticks");

    c_fast_valid: cover property ($rose(fast_clk_valid));
    c_slow_valid: cover property ($rose(slow_clk_valid));
    c_sleep_cancel: cover property (sleep ##1 sleep_cancel);
    c_cal_start: cover property (slow_div_reset);
endmodule
`default_nettype wire

/* src/doc_defines.svh */
`ifndef DOC_DEFINES_SVH
`define DOC_DEFINES_SVH
`define DOC_SYS_CLK_HZ 100000000
`define DOC_FAST_HZ_2M 2000000
`define DOC_FAST_HZ_1M 1000000
`define DOC_FAST_HZ_500K 500000
`define DOC_FAST_DIV_2M 8'(`DOC_SYS_CLK_HZ / `DOC_FAST_HZ_2M)
`define DOC_FAST_DIV_1M 8'(`DOC_SYS_CLK_HZ / `DOC_FAST_HZ_1M)
`define DOC_FAST_DIV_500K 8'(`DOC_SYS_CLK_HZ / `DOC_FAST_HZ_500K)
`define DOC_FAST_WAIT_8 16'h0008
`define DOC_FAST_WAIT_16 16'h0010
`define DOC_FAST_WAIT_32 16'h0020
`define DOC_FAST_WAIT_64 16'h0040
`define DOC_SLOW_WAIT_LONG 16384
`define DOC_SLOW_WAIT_SHORT 4096
`define DOC_SLOW_HZ 32768
`define DOC_TAP_HZ 256
`define DOC_TAP_DIV 7'((`DOC_SLOW_HZ / `DOC_TAP_HZ) - 1)
`define DOC_ADDR_SRC 5'h00
`define DOC_ADDR_CTL 5'h04
`define DOC_ADDR_WAIT 5'h08
`define DOC_ADDR_CAL 5'h0C
`define DOC_ADDR_PORT 5'h10
`define DOC_SRC_LSB 0
`define DOC_FSEL_LSB 4
`define DOC_FEN_BIT 0
`define DOC_SEN_BIT 1
`define DOC_FWT_LSB 0
`define DOC_SWT_LSB 4
`define DOC_CAL_BIT 0
`define DOC_FVAL_BIT 8
`define DOC_SVAL_BIT 9
`define DOC_FRUN_BIT 10
`define DOC_SRUN_BIT 11
`define DOC_PORTA_BIT 0
`define DOC_PORTB_BIT 1
`define DOC_SRC_FAST 2'h0
`define DOC_SRC_SLOW 2'h1
`define DOC_FSEL_RST 2'h0
`define DOC_FWT_RST 2'h0
`define DOC_SWT_RST 2'h0
`define DOC_FEN_RST 1'b1
`define DOC_SEN_RST 1'b0
`define DOC_CAL_RST 1'b0
`endif

/* src/doc_pkg.sv */
`include "doc_defines.svh"
package doc_pkg;
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } doc_osc_st_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic valid;
    } doc_wait_st_t;

    typedef struct packed {
        logic [1:0] src;
        logic [1:0] fsel;
        logic fen;
        logic sen;
        logic [1:0] fwt;
        logic [1:0] swt;
        logic cal;
        logic port_a;
        logic port_b;
        logic fast_run;
        logic slow_run;
        logic [2:0] xsync;
        logic slow_tick;
        logic [6:0] tap_cnt;
        logic tap;
        logic div_rst;
        logic sys_tick;
        logic core_run;
        logic fdiv;
        logic out_a;
        logic out_b;
        logic xout;
        logic [15:0] rdata;
    } doc_main_st_t;

    function automatic logic [7:0] fast_div(input logic [1:0] sel);
        unique case (sel)
            2'h1: fast_div = `DOC_FAST_DIV_1M;
            2'h2: fast_div = `DOC_FAST_DIV_500K;
            default: fast_div = `DOC_FAST_DIV_2M;
        endcase
    endfunction

    function automatic logic [15:0] fast_wait(input logic [1:0] sel);
        unique case (sel)
            2'h3: fast_wait = `DOC_FAST_WAIT_8;
            2'h2: fast_wait = `DOC_FAST_WAIT_16;
            2'h1: fast_wait = `DOC_FAST_WAIT_32;
            default: fast_wait = `DOC_FAST_WAIT_64;
        endcase
    endfunction
endpackage

/* src/doc_fast_osc.sv */
`timescale 1ns/1ps
`default_nettype none
`include "doc_defines.svh"
module doc_fast_osc (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic [1:0] freq_sel,
    output logic tick
);
    doc_pkg::doc_osc_st_t s;
    doc_pkg::doc_osc_st_t next_s;

    always_comb
    begin
        next_s = s;
        next_s.tick = 1'b0;
        if (!run)
        begin
            next_s.cnt = 8'h00;
        end
        else if (s.cnt >= doc_pkg::fast_div(freq_sel) - 8'h01)
        begin
            next_s.cnt = 8'h00;
            next_s.tick = 1'b1;
        end
        else
        begin
            next_s.cnt = s.cnt + 8'h01;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            s <= '0;
        else
            s <= next_s;
    end

    assign tick = s.tick;
endmodule
`default_nettype wire

/* src/doc_osc_wait.sv */
`timescale 1ns/1ps
`default_nettype none
module doc_osc_wait (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic tick,
    input wire logic [15:0] limit,
    output logic valid
);
    doc_pkg::doc_wait_st_t s;
    doc_pkg::doc_wait_st_t next_s;

    always_comb
    begin
        next_s = s;
        if (!run)
        begin
            next_s.cnt = 16'h0000;
            next_s.valid = 1'b0;
        end
        else if (tick && !s.valid)
        begin
            next_s.cnt = s.cnt + 16'h0001;
            if (next_s.cnt >= limit)
                next_s.valid = 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            s <= '0;
        else
            s <= next_s;
    end

    assign valid = s.valid;
endmodule
`default_nettype wire

/* tb/doc_osc_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "doc_defines.svh"
module doc_osc_ctrl_tb;
    localparam int SLONG = 16;
    localparam int SSHORT = 4;
    logic sys_clk, sys_rst, reg_wr, reg_rd, sleep, sleep_cancel, crystal_in_pin, gpio_a, gpio_b;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic crystal_out_pin, clock_out_a, clock_out_b, sysclk_tick, core_run, fast_osc_run, slow_osc_run;
    logic fast_clk_valid, slow_clk_valid, tap_256hz, slow_div_reset;
    logic [1:0] sysclk_source_sel;
    int num_errors = 0;
    int checked = 0;
    int seed = 32'hFD3FE3FE;
    int m_src, m_fen, m_sen, m_fsel, m_wait, m_cal, m_port, early, n, p, t0, tg;
    logic va, vb, la, lb;

    doc_osc_ctrl #(.SLOW_WAIT_LONG(SLONG), .SLOW_WAIT_SHORT(SSHORT)) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep(sleep), .sleep_cancel(sleep_cancel),
        .crystal_in_pin(crystal_in_pin), .crystal_out_pin(crystal_out_pin), .gpio_a(gpio_a), .gpio_b(gpio_b),
        .clock_out_a(clock_out_a), .clock_out_b(clock_out_b), .sysclk_source_sel(sysclk_source_sel),
        .sysclk_tick(sysclk_tick), .core_run(core_run), .fast_osc_run(fast_osc_run),
        .slow_osc_run(slow_osc_run), .fast_clk_valid(fast_clk_valid), .slow_clk_valid(slow_clk_valid),
        .tap_256hz(tap_256hz), .slow_div_reset(slow_div_reset));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial
    begin
        forever
        begin
            repeat (8) @(posedge sys_clk);
            crystal_in_pin <= ~crystal_in_pin;
        end
    end

    always @(posedge sys_clk)
    begin
        if (sysclk_tick === 1'b1 && fast_clk_valid !== 1'b1 && core_run !== 1'b1)
            early <= early + 1;
    end

    task automatic final_report();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic chk_rng(input string name, input int lo, input int hi, input int got);
        checked++;
        if (got < lo || got > hi)
        begin
            num_errors++;
            $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask

    function automatic logic sig(input int s);
        case (s)
            0: sig = fast_clk_valid;
            1: sig = slow_clk_valid;
            2: sig = core_run;
            3: sig = sysclk_tick;
            4: sig = tap_256hz;
            5: sig = fast_osc_run;
            default: sig = slow_osc_run;
        endcase
    endfunction

    task automatic wait_sig(input int s, input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (sig(s) !== lvl && cnt < lim)
        begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end
        if (cnt >= lim)
        begin
            num_errors++;
            $display("ERROR wait_%0d expected %0b seen timeout", s, lvl);
        end
    endtask

    task automatic period(input int s, output int cnt);
        int k;
        wait_sig(s, 1'b1, 3000, k);
        @(posedge sys_clk);
        #1;
        wait_sig(s, 1'b1, 3000, cnt);
        cnt = cnt + 1;
    endtask

    function automatic logic [15:0] model(input logic [4:0] a);
        case (a)
            `DOC_ADDR_SRC: model = 16'(m_src | (m_fsel << 4));
            `DOC_ADDR_CTL: model = 16'(m_fen | (m_sen << 1));
            `DOC_ADDR_WAIT: model = 16'(m_wait);
            `DOC_ADDR_CAL: model = 16'(m_cal);
            `DOC_ADDR_PORT: model = 16'(m_port);
            default: model = 16'h0000;
        endcase
    endfunction

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
        case (a)
            `DOC_ADDR_SRC:
            begin
                if ((d[1:0] == 2'h0 && m_fen == 1) || (d[1:0] == 2'h1 && m_sen == 1))
                    m_src = d[1:0];
                m_fsel = d[5:4];
            end
            `DOC_ADDR_CTL:
            begin
                m_fen = d[0] | (m_src == 0);
                m_sen = d[1] | (m_src == 1);
            end
            `DOC_ADDR_WAIT: m_wait = d & 16'h0033;
            `DOC_ADDR_CAL: m_cal = d[0];
            `DOC_ADDR_PORT: m_port = d & 16'h0003;
            default: m_port = m_port;
        endcase
    endtask

    task automatic rd(input logic [4:0] a);
        logic [15:0] mask;
        case (a)
            `DOC_ADDR_SRC, `DOC_ADDR_WAIT: mask = 16'h0033;
            `DOC_ADDR_CTL, `DOC_ADDR_PORT: mask = 16'h0003;
            `DOC_ADDR_CAL: mask = 16'h0001;
            default: mask = 16'hFFFF;
        endcase
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", model(a) & mask, reg_rdata & mask);
        @(posedge sys_clk);
        #1;
        chk("reg_rdata_idle", 16'h0000, reg_rdata);
    endtask

    initial
    begin
        repeat (100000) @(posedge sys_clk);
        num_errors++;
        final_report();
    end

    initial
    begin
        {sys_rst, reg_wr, reg_rd, sleep, sleep_cancel, crystal_in_pin, gpio_a, gpio_b} = 8'h80;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        {m_src, m_fsel, m_sen, m_wait, m_cal, m_port, early} = '0;
        m_fen = 1;
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        chk("run_flags", 16'h0001, {slow_osc_run, fast_osc_run});
        chk("src_sel", 16'h0000, 16'(sysclk_source_sel));
        for (int a = 0; a < 24; a += 4)
            rd(5'(a));
        for (int i = 0; i < 6; i++)
        begin
            va = $random(seed);
            vb = $random(seed);
            @(posedge sys_clk);
            gpio_a <= va;
            gpio_b <= vb;
            @(posedge sys_clk);
            #1;
            chk("clock_out_gpio", 16'({vb, va}), 16'({clock_out_b, clock_out_a}));
        end
        chk("core_run_early", 16'h0000, 16'(core_run));
        wait_sig(2, 1'b1, 5000, n);
        chk_rng("core_start", 64 * 50 - 50, 64 * 50 + 120, n + 52);
        chk("tick_before_valid", 16'h0000, 16'(early));
        for (int f = 0; f < 4; f++)
        begin
            wr(`DOC_ADDR_SRC, 16'(f << 4));
            period(3, p);
            period(3, p);
            chk_rng("fast_period", (f == 3) ? 50 : 50 << f, (f == 3) ? 50 : 50 << f, p);
        end
        wr(`DOC_ADDR_SRC, 16'h0000);
        wr(`DOC_ADDR_CTL, 16'h0000);
        rd(`DOC_ADDR_CTL);
        chk("fast_kept", 16'h0001, 16'(fast_osc_run));
        for (int i = 0; i < 4; i++)
        begin
            wr(`DOC_ADDR_CTL, 16'h0001 | 16'((i & 1) << 1));
            wr(`DOC_ADDR_CAL, 16'(i >> 1));
            @(posedge sys_clk);
            sleep <= 1'b1;
            repeat (4) @(posedge sys_clk);
            #1;
            chk("sleep_run", 16'((i & 1) & (i >> 1)), 16'({fast_osc_run, slow_osc_run}));
            sleep <= 1'b0;
            repeat (4) @(posedge sys_clk);
            #1;
            chk("wake_run", 16'h0002 | 16'(i & 1), 16'({fast_osc_run, slow_osc_run}));
        end
        wr(`DOC_ADDR_CAL, 16'h0000);
        wait_sig(1, 1'b1, 2000, n);
        wr(`DOC_ADDR_CAL, 16'h0001);
        chk("div_reset", 16'h0001, 16'(slow_div_reset));
        wr(`DOC_ADDR_CAL, 16'h0001);
        chk("div_reset_hold", 16'h0000, 16'(slow_div_reset));
        period(4, p);
        chk_rng("tap_period", 128 * 16, 128 * 16, p);
        for (int w = 0; w < 4; w++)
        begin
            wr(`DOC_ADDR_WAIT, 16'(w << 4));
            wr(`DOC_ADDR_CTL, 16'h0001);
            wait_sig(1, 1'b0, 8, n);
            wr(`DOC_ADDR_CTL, 16'h0003);
            wait_sig(1, 1'b1, 2000, n);
            tg = (w == 2) ? SSHORT : SLONG;
            chk_rng("slow_wait", tg * 16 - 20, tg * 16 + 24, n);
        end
        wr(`DOC_ADDR_SRC, 16'h0001);
        rd(`DOC_ADDR_SRC);
        period(3, p);
        chk_rng("slow_sys_period", 16, 16, p);
        wr(`DOC_ADDR_SRC, 16'h0002);
        wr(`DOC_ADDR_CTL, 16'h0001);
        rd(`DOC_ADDR_SRC);
        rd(`DOC_ADDR_CTL);
        for (int w = 3; w >= 0; w--)
        begin
            wr(`DOC_ADDR_WAIT, 16'(w));
            wr(`DOC_ADDR_CTL, 16'h0002);
            wait_sig(5, 1'b0, 4, n);
            @(posedge sys_clk);
            #1;
            chk("fast_valid_clr", 16'h0000, 16'(fast_clk_valid));
            wr(`DOC_ADDR_CTL, 16'h0003);
            wait_sig(0, 1'b1, 5000, n);
            chk_rng("fast_wait", (8 << (3 - w)) * 50 - 50, (8 << (3 - w)) * 50 + 60, n);
        end
        wr(`DOC_ADDR_CTL, 16'h0002);
        @(posedge sys_clk);
        sleep <= 1'b1;
        repeat (4) @(posedge sys_clk);
        sleep <= 1'b0;
        sleep_cancel <= 1'b1;
        @(posedge sys_clk);
        sleep_cancel <= 1'b0;
        m_fen = 1;
        m_src = 0;
        repeat (2) @(posedge sys_clk);
        #1;
        rd(`DOC_ADDR_SRC);
        rd(`DOC_ADDR_CTL);
        chk("fast_after_cancel", 16'h0001, 16'(fast_osc_run));
        wait_sig(0, 1'b1, 5000, n);
        wr(`DOC_ADDR_PORT, 16'h0003);
        tg = 0;
        la = clock_out_a;
        lb = clock_out_b;
        for (int i = 0; i < 400; i++)
        begin
            @(posedge sys_clk);
            #1;
            tg += (clock_out_a !== la) + (clock_out_b !== lb);
            la = clock_out_a;
            lb = clock_out_b;
        end
        chk_rng("clock_out_toggles", 14, 18, tg);
        rd(`DOC_ADDR_PORT);
        final_report();
    end
endmodule
`default_nettype wire
